// file: core/sltx_defines.svh
`ifndef SLTX_DEFINES_SVH
`define SLTX_DEFINES_SVH

// clock and line timing
`define SLTX_PCLK_MHZ      100
`define SLTX_LPX_NS        50
`define SLTX_PREP_NS       60
`define SLTX_ZERO_NS       150
`define SLTX_TRAIL_NS      70
`define SLTX_EXIT_NS       100
`define SLTX_LPX_CYC       (8'((`SLTX_LPX_NS * `SLTX_PCLK_MHZ + 999) / 1000))
`define SLTX_PREP_CYC      (8'((`SLTX_PREP_NS * `SLTX_PCLK_MHZ + 999) / 1000))
`define SLTX_ZERO_CYC      (8'((`SLTX_ZERO_NS * `SLTX_PCLK_MHZ + 999) / 1000))
`define SLTX_TRAIL_CYC     (8'((`SLTX_TRAIL_NS * `SLTX_PCLK_MHZ + 999) / 1000))
`define SLTX_EXIT_CYC      (8'((`SLTX_EXIT_NS * `SLTX_PCLK_MHZ + 999) / 1000))

// byte clock divider: one bit per pclk, eight bits per byte
`define SLTX_BYTE_LAST     3'h7
`define SLTX_BYTE_HALF     3'h4

// line patterns
`define SLTX_SYNC_BYTE     8'hB8
`define SLTX_SKEW_SYNC     8'hFF
`define SLTX_SKEW_PAT      8'hAA
`define SLTX_SKEW_MIN_RATE 16'h05DC
`define SLTX_ESC_LAST_PH   2'h3

// synchroniser bit positions
`define SLTX_SY_W          11
`define SLTX_SY_CLK        0
`define SLTX_SY_REQ        1
`define SLTX_SY_LPDT       2
`define SLTX_SY_ULPS       3
`define SLTX_SY_EXIT       4
`define SLTX_SY_TRIG_LO    5
`define SLTX_SY_TRIG_HI    8
`define SLTX_SY_FORCE      9
`define SLTX_SY_EN         10

// register map and reset values
`define SLTX_OFF_CTRL      8'h00
`define SLTX_OFF_RATE      8'h04
`define SLTX_OFF_STATUS    8'h08
`define SLTX_CTRL_SKEW     0
`define SLTX_RATE_RST      16'h05DC
`define SLTX_ST_STOP_BIT   4
`define SLTX_ST_ULPS_BIT   5
`define SLTX_ST_HS_BIT     6

`endif

// file: core/sltx_pkg.sv
package sltx_pkg;

    // lane state machine
    typedef enum logic [3:0] {
        ST_STOP, ST_HS_LPX, ST_HS_PREP, ST_HS_ZERO, ST_HS_DATA, ST_HS_SKEW,
        ST_HS_TRAIL, ST_HS_EXIT, ST_ESC_ENTRY, ST_ESC_LPDT, ST_ESC_TRIG,
        ST_ULPS, ST_ESC_MARK
    } sltx_state_t;

    // escape request group from the controller
    typedef struct packed {
        logic       req;
        logic       lpdt;
        logic       ulps;
        logic       ulps_exit;
        logic [3:0] trig;
    } sltx_esc_t;

    // lane line drive
    typedef struct packed {
        logic hs_en;
        logic hs_dout;
        logic lp_p;
        logic lp_n;
    } sltx_line_t;

    // synchroniser state
    typedef struct packed {
        logic [10:0] s1;
        logic [10:0] s2;
    } sltx_sync_t;

    // lane core state
    typedef struct packed {
        sltx_state_t state;
        logic [7:0]  cnt;
        logic [1:0]  phase;
        logic [2:0]  bcnt;
        logic        byte_clk;
        logic [7:0]  shift;
        logic        skew;
        logic        hs_req_prev;
        logic        skew_prev;
        logic        esc_clk_prev;
        logic        ready;
        logic        stop;
        logic        ulps_n;
        sltx_line_t  line;
        logic        ctrl_skew;
        logic [15:0] rate;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } sltx_core_t;

endpackage

// file: core/sltx_sync.sv
`timescale 1ns/1ns
`include "sltx_defines.svh"

module sltx_sync (
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // raw and synchronised levels
    input  wire logic [`SLTX_SY_W-1:0]   din,
    output logic      [`SLTX_SY_W-1:0]   dout
);

    sltx_pkg::sltx_sync_t q;
    sltx_pkg::sltx_sync_t d;

    // two-stage shift per bit
    always_comb begin
        d    = q;
        d.s1 = din;
        d.s2 = q.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;

endmodule

// file: core/sltx_lane.sv
`timescale 1ns/1ns
`include "sltx_defines.svh"

// Notes on behaviour
// - byte clock is bit rate over eight
// - byte taken on byte edge, LSB first
// - request rise starts start-of-transmission
// - request fall starts end-of-transmission
// - byte taken when request and accept high
// - high-speed request wins over escape request
// - deskew rise sends pattern, fall ends it
// - deskew only above 1500 and when enabled
// - force-stop puts machine into Stop
// - escape phases timed by escape clock period
// - escape mode held until escape request falls
// - low-power data mode until request falls
// - ulps state held until request falls or ulps exit is high
// - ulps exit drives Mark-1, then Stop
// - ulps exit ignored outside ulps state
// - stop indication high in Stop state
// - disabled lane ignores ppi inputs, ppi outputs inactive except byte clock
// - active-low ulps indication low in ulps
module sltx_lane (
    // clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [7:0]           paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // high-speed transmit group
    output logic                      byte_clk,
    input  wire logic [7:0]           hs_tx_data,
    input  wire logic                 hs_tx_req,
    output logic                      hs_tx_ready,
    input  wire logic                 skew_req,
    // escape group and control
    input  wire logic                 esc_clk,
    input  wire sltx_pkg::sltx_esc_t  esc,
    input  wire logic                 force_stop,
    input  wire logic                 lane_enable,
    // lane status and line
    output logic                      stop_state,
    output logic                      ulps_active_n,
    output sltx_pkg::sltx_line_t      line
);

    sltx_pkg::sltx_core_t q;
    sltx_pkg::sltx_core_t n;
    logic [`SLTX_SY_W-1:0] sy;
    logic                  tick;
    logic                  esc_tick;
    logic                  en;
    logic                  skew_ok;
    logic                  unmapped;
    logic [31:0]           rd_val;

    ////////////////////////////////////////////////////////////////////////
    // synchronisers for everything off the pclk domain
    sltx_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({lane_enable, force_stop, esc.trig, esc.ulps_exit, esc.ulps,
                   esc.lpdt, esc.req, esc_clk}),
        .dout    (sy)
    );

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        n        = q;
        en       = sy[`SLTX_SY_EN];
        // divider: byte edge once every eight pclk cycles
        tick     = (q.bcnt == `SLTX_BYTE_LAST);
        n.bcnt   = q.bcnt + 3'h1;
        n.byte_clk = (n.bcnt < `SLTX_BYTE_HALF);
        // escape clock rising edge seen on the synchronised level
        esc_tick = sy[`SLTX_SY_CLK] & ~q.esc_clk_prev;
        n.esc_clk_prev = sy[`SLTX_SY_CLK];
        skew_ok  = q.ctrl_skew && (q.rate > `SLTX_SKEW_MIN_RATE);
        // serializer shifts one bit per cycle, fill holds the top bit
        n.shift  = {q.shift[7], q.shift[7:1]};
        if (q.cnt != 8'h00) begin
            n.cnt = q.cnt - 8'h01;
        end
        if (tick) begin
            n.hs_req_prev = hs_tx_req;
            n.skew_prev   = skew_req;
        end

        case (q.state)
            sltx_pkg::ST_STOP: begin
                // high-speed checked first so it wins over escape
                if (tick && hs_tx_req && !q.hs_req_prev) begin
                    n.state = sltx_pkg::ST_HS_LPX;
                    n.cnt   = `SLTX_LPX_CYC;
                    n.skew  = 1'h0;
                end else if (tick && skew_ok && skew_req && !q.skew_prev) begin
                    n.state = sltx_pkg::ST_HS_LPX;
                    n.cnt   = `SLTX_LPX_CYC;
                    n.skew  = 1'h1;
                end else if (esc_tick && sy[`SLTX_SY_REQ] && !hs_tx_req) begin
                    n.state = sltx_pkg::ST_ESC_ENTRY;
                    n.phase = 2'h0;
                end
            end
            sltx_pkg::ST_HS_LPX: begin
                if (q.cnt == 8'h00) begin
                    n.state = sltx_pkg::ST_HS_PREP;
                    n.cnt   = `SLTX_PREP_CYC;
                end
            end
            sltx_pkg::ST_HS_PREP: begin
                if (q.cnt == 8'h00) begin
                    n.state = sltx_pkg::ST_HS_ZERO;
                    n.cnt   = `SLTX_ZERO_CYC;
                    n.shift = 8'h00;
                end
            end
            sltx_pkg::ST_HS_ZERO: begin
                // leader zeros, then sync byte aligned to a byte edge
                if (tick && q.cnt == 8'h00) begin
                    n.shift = q.skew ? `SLTX_SKEW_SYNC : `SLTX_SYNC_BYTE;
                    n.state = q.skew ? sltx_pkg::ST_HS_SKEW : sltx_pkg::ST_HS_DATA;
                end
            end
            sltx_pkg::ST_HS_DATA: begin
                if (tick) begin
                    if (hs_tx_req && q.ready) begin
                        n.shift = hs_tx_data;
                    end else if (!hs_tx_req) begin
                        n.state = sltx_pkg::ST_HS_TRAIL;
                        n.shift = {8{~q.shift[0]}};
                        n.cnt   = `SLTX_TRAIL_CYC;
                    end
                end
            end
            sltx_pkg::ST_HS_SKEW: begin
                if (tick) begin
                    if (skew_req) begin
                        n.shift = `SLTX_SKEW_PAT;
                    end else begin
                        n.state = sltx_pkg::ST_HS_TRAIL;
                        n.shift = {8{~q.shift[0]}};
                        n.cnt   = `SLTX_TRAIL_CYC;
                    end
                end
            end
            sltx_pkg::ST_HS_TRAIL: begin
                if (q.cnt == 8'h00) begin
                    n.state = sltx_pkg::ST_HS_EXIT;
                    n.cnt   = `SLTX_EXIT_CYC;
                end
            end
            sltx_pkg::ST_HS_EXIT: begin
                if (q.cnt == 8'h00) begin
                    n.state = sltx_pkg::ST_STOP;
                end
            end
            sltx_pkg::ST_ESC_ENTRY: begin
                // one line phase per escape clock period
                if (esc_tick) begin
                    if (!sy[`SLTX_SY_REQ]) begin
                        n.state = sltx_pkg::ST_ESC_MARK;
                    end else if (q.phase != `SLTX_ESC_LAST_PH) begin
                        n.phase = q.phase + 2'h1;
                    end else if (sy[`SLTX_SY_LPDT]) begin
                        n.state = sltx_pkg::ST_ESC_LPDT;
                    end else if (sy[`SLTX_SY_ULPS]) begin
                        n.state = sltx_pkg::ST_ULPS;
                    end else if (sy[`SLTX_SY_TRIG_HI:`SLTX_SY_TRIG_LO] != 4'h0) begin
                        n.state = sltx_pkg::ST_ESC_TRIG;
                    end else begin
                        n.state = sltx_pkg::ST_ESC_MARK;
                    end
                end
            end
            sltx_pkg::ST_ESC_LPDT, sltx_pkg::ST_ESC_TRIG: begin
                if (esc_tick && !sy[`SLTX_SY_REQ]) begin
                    n.state = sltx_pkg::ST_ESC_MARK;
                end
            end
            sltx_pkg::ST_ULPS: begin
                // exit only looked at here, elsewhere it is ignored
                if (esc_tick && (sy[`SLTX_SY_EXIT] || !sy[`SLTX_SY_REQ])) begin
                    n.state = sltx_pkg::ST_ESC_MARK;
                end
            end
            sltx_pkg::ST_ESC_MARK: begin
                if (esc_tick && !sy[`SLTX_SY_REQ]) begin
                    n.state = sltx_pkg::ST_STOP;
                end
            end
            default: begin
                n.state = sltx_pkg::ST_STOP;
            end
        endcase

        // force-stop and disable override everything
        if (sy[`SLTX_SY_FORCE] || !en) begin
            n.state = sltx_pkg::ST_STOP;
            n.cnt   = 8'h00;
            n.phase = 2'h0;
        end

        // line levels and status from the next state
        n.line.hs_en = 1'h0;
        n.line.lp_p  = 1'h0;
        n.line.lp_n  = 1'h0;
        case (n.state)
            sltx_pkg::ST_STOP, sltx_pkg::ST_HS_EXIT: begin
                n.line.lp_p = 1'h1;
                n.line.lp_n = 1'h1;
            end
            sltx_pkg::ST_HS_LPX: begin
                n.line.lp_n = 1'h1;
            end
            sltx_pkg::ST_HS_ZERO, sltx_pkg::ST_HS_DATA, sltx_pkg::ST_HS_SKEW,
            sltx_pkg::ST_HS_TRAIL: begin
                n.line.hs_en = 1'h1;
            end
            sltx_pkg::ST_ESC_ENTRY: begin
                // entry walk: LP-10, LP-00, LP-01, LP-00
                n.line.lp_p = (n.phase == 2'h0);
                n.line.lp_n = (n.phase == 2'h2);
            end
            sltx_pkg::ST_ESC_MARK: begin
                n.line.lp_p = 1'h1;
            end
            default: begin
                n.line.lp_p = 1'h0;
            end
        endcase
        n.line.hs_dout = n.line.hs_en & n.shift[0]; // leader starts clean
        if (!en) begin
            n.line.lp_p = 1'h0;
            n.line.lp_n = 1'h0;
        end
        n.stop   = en && (n.state == sltx_pkg::ST_STOP);
        n.ulps_n = !(en && (n.state == sltx_pkg::ST_ULPS));
        n.ready  = en && (n.state == sltx_pkg::ST_HS_DATA);

        ////////////////////////////////////////////////////////////////////
        // apb slave: setup cycle loads the answer, access cycle completes
        unmapped = (paddr != `SLTX_OFF_CTRL) && (paddr != `SLTX_OFF_RATE) &&
                   (paddr != `SLTX_OFF_STATUS);
        rd_val   = 32'h0000_0000;
        case (paddr)
            `SLTX_OFF_CTRL: begin
                rd_val[`SLTX_CTRL_SKEW] = q.ctrl_skew;
            end
            `SLTX_OFF_RATE: begin
                rd_val[15:0] = q.rate;
            end
            `SLTX_OFF_STATUS: begin
                rd_val[3:0]               = q.state;
                rd_val[`SLTX_ST_STOP_BIT] = q.stop;
                rd_val[`SLTX_ST_ULPS_BIT] = ~q.ulps_n;
                rd_val[`SLTX_ST_HS_BIT]   = q.line.hs_en;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
        if (psel && !penable && !q.pready) begin
            n.pready  = 1'h1;
            n.pslverr = unmapped;
            n.prdata  = pwrite ? 32'h0000_0000 : rd_val;
        end else if (psel && penable && q.pready) begin
            n.pready  = 1'h0;
            n.pslverr = 1'h0;
            if (pwrite && paddr == `SLTX_OFF_CTRL) begin
                n.ctrl_skew = pwdata[`SLTX_CTRL_SKEW];
            end
            if (pwrite && paddr == `SLTX_OFF_RATE) begin
                n.rate = pwdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q        <= '0;
            q.ulps_n <= 1'h1;
            q.byte_clk <= 1'h1; // bcnt of zero sits in the high half
            q.rate   <= `SLTX_RATE_RST;
        end else begin
            q <= n;
        end
    end

    // outputs straight from flops
    assign prdata        = q.prdata;
    assign pready        = q.pready;
    assign pslverr       = q.pslverr;
    assign byte_clk      = q.byte_clk;
    assign hs_tx_ready   = q.ready;
    assign stop_state    = q.stop;
    assign ulps_active_n = q.ulps_n;
    assign line          = q.line;

endmodule

// file: test/sltx_lane_chk.sv
`timescale 1ns/1ns
module sltx_lane_chk (
    // clock and reset
    input wire logic                 pclk,
    input wire logic                 presetn,
    // lane ports
    input wire logic                 byte_clk,
    input wire logic                 hs_tx_req,
    input wire logic                 hs_tx_ready,
    input wire logic                 skew_req,
    input wire sltx_pkg::sltx_esc_t  esc,
    input wire logic                 force_stop,
    input wire logic                 lane_enable,
    input wire logic                 stop_state,
    input wire logic                 ulps_active_n,
    input wire sltx_pkg::sltx_line_t line
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // lane left alone by force and disable
    wire ok = lane_enable && !force_stop;
    //////////////////////////////////////////////////////////////////
    property p_byte_clk;
        $rose(byte_clk) |=> byte_clk[*3] ##1 !byte_clk[*4] ##1 byte_clk;
    endproperty
    a_byte_clk: assert property (p_byte_clk)
        else $error("byte clock shape wrong");
    property p_sot;
        $rose(hs_tx_req) && stop_state && ok |-> ##[1:12] (!line.lp_p && line.lp_n);
    endproperty
    a_sot: assert property (p_sot)
        else $error("no start sequence");
    property p_eot;
        $fell(hs_tx_ready) && !hs_tx_req && ok |-> !stop_state ##[1:40] stop_state;
    endproperty
    a_eot: assert property (p_eot)
        else $error("no end sequence");
    property p_accept;
        hs_tx_ready |-> line.hs_en && !stop_state && ulps_active_n;
    endproperty
    a_accept: assert property (p_accept)
        else $error("accept outside data phase");
    property p_stop;
        stop_state |-> line.lp_p && line.lp_n && !line.hs_en && !hs_tx_ready;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stop without idle lines");
    property p_force;
        (force_stop && lane_enable)[*5] |-> stop_state;
    endproperty
    a_force: assert property (p_force)
        else $error("force stop ignored");
    property p_off;
        (!lane_enable)[*4] |-> !stop_state && !hs_tx_ready && ulps_active_n
            && !line.lp_p && !line.lp_n;
    endproperty
    a_off: assert property (p_off)
        else $error("disabled lane not inactive");
    property p_ulps;
        !ulps_active_n |-> !line.lp_p && !line.lp_n && !stop_state;
    endproperty
    a_ulps: assert property (p_ulps)
        else $error("ulps lines wrong");
    property p_mark;
        $rose(ulps_active_n) && ok |-> line.lp_p && !line.lp_n;
    endproperty
    a_mark: assert property (p_mark)
        else $error("no mark after ulps");
    property p_quiet;
        (ok && !hs_tx_req && !skew_req && !esc.req)[*4] ##0 stop_state |=> stop_state;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("stop left without request");
endmodule

bind sltx_lane sltx_lane_chk chk_u (.pclk, .presetn, .byte_clk, .hs_tx_req, .hs_tx_ready,
    .skew_req, .esc, .force_stop, .lane_enable, .stop_state, .ulps_active_n, .line);

// file: test/sltx_ctrl_model.sv
`timescale 1ns/1ns
module sltx_ctrl_model (
    // lane clocks and status
    input  wire logic           pclk,
    input  wire logic           byte_clk,
    input  wire logic           hs_tx_ready,
    // ppi drive
    output logic [7:0]          hs_tx_data,
    output logic                hs_tx_req,
    output logic                skew_req,
    output logic                esc_clk,
    output sltx_pkg::sltx_esc_t esc
);
    logic       bc_q, rdy_q, esc_run;
    logic [7:0] taken[$];
    initial begin
        {hs_tx_data, hs_tx_req, skew_req, esc_clk, esc, esc_run} = '0;
    end
    // escape clock, still when idle
    always #80 esc_clk <= esc_run && !esc_clk;
    // settled byte clock and accept before each edge
    always @(negedge pclk) begin
        bc_q <= byte_clk;
        rdy_q <= hs_tx_ready;
    end
    // burst only while escape idle
    task automatic send_hs(input int n, input logic skew);
        int to;
        to = 0;
        @(posedge pclk);
        hs_tx_data <= 8'($urandom);
        skew_req <= skew;
        hs_tx_req <= !skew;
        while (n > 0 && to < 600) begin
            @(negedge pclk);
            to++;
            if (byte_clk && !bc_q && (rdy_q || skew)) begin
                taken.push_back(hs_tx_data);
                n--;
                @(posedge pclk);
                hs_tx_data <= 8'($urandom);
            end
        end
        @(posedge pclk);
        hs_tx_req <= 1'b0;
        skew_req <= 1'b0;
    endtask
    // one selection with the request
    task automatic esc_on(input logic lp, input logic ul, input logic [3:0] tr);
        @(posedge pclk);
        esc_run <= 1'b1;
        esc <= '{req: 1'b1, lpdt: lp, ulps: ul, ulps_exit: 1'b0, trig: tr};
    endtask
    task automatic esc_exit;
        @(posedge pclk);
        esc_run <= 1'b1;
        esc.ulps_exit <= 1'b1;
    endtask
    task automatic esc_off;
        @(posedge pclk);
        esc <= '0;
        repeat (64) @(posedge pclk);
        esc_run <= 1'b0;
    endtask
endmodule

// file: test/sltx_lane_test.sv
`timescale 1ns/1ns
module sltx_lane_test;
    logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]           paddr, hs_tx_data, b;
    logic [31:0]          pwdata, prdata, rd;
    logic                 byte_clk, hs_tx_req, hs_tx_ready, skew_req, esc_clk;
    logic                 force_stop, lane_enable, stop_state, ulps_active_n;
    sltx_pkg::sltx_esc_t  esc;
    sltx_pkg::sltx_line_t line;
    logic                 bits[$];
    int                   err_total, n_tests, m;

    sltx_lane dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .byte_clk, .hs_tx_data, .hs_tx_req, .hs_tx_ready, .skew_req,
        .esc_clk, .esc, .force_stop, .lane_enable, .stop_state, .ulps_active_n, .line);
    sltx_ctrl_model ctrl_u (.pclk, .byte_clk, .hs_tx_ready, .hs_tx_data, .hs_tx_req,
        .skew_req, .esc_clk, .esc);

    // clock
    always #5 pclk = ~pclk;
    // serial bits while high speed drives
    always @(negedge pclk) if (line.hs_en === 1'b1) bits.push_back(line.hs_dout);
    //////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int to;
        to = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            to++;
        end while (pready !== 1'b1 && to < 20);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'b00;
        cmp(32'(to < 20), 32'h1);
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: return stop_state;
            1: return ulps_active_n;
            default: return hs_tx_ready;
        endcase
    endfunction
    // bounded wait for a level
    task automatic wt(input int k, input logic v);
        int to;
        to = 0;
        while (sig(k) !== v && to < 3000) begin
            @(posedge pclk);
            to++;
        end
        cmp(32'(sig(k)), 32'(v));
    endtask
    // bytes follow the sync byte lsb first
    task automatic chk_stream;
        int i;
        i = 0;
        while (i < bits.size() && bits[i] !== 1'b1)
            i++;
        foreach (ctrl_u.taken[k]) begin
            for (int j = 0; j < 8; j++)
                b[j] = bits[i + 5 + 8 * k + j];
            cmp(32'(b), 32'(ctrl_u.taken[k]));
        end
    endtask
    // watchdog
    initial begin
        #400000;
        err_total++;
        report_and_stop();
    end
    // main sequence
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata, force_stop} = '0;
        lane_enable = 1'b1;
        void'($urandom(32'h8EFA));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        wt(0, 1'b1);
        cmp({line.lp_p, line.lp_n, ulps_active_n}, 3'h7);
        apb(1'b0, 8'h04, 0);
        cmp(rd, 32'h05DC);
        apb(1'b0, 8'h08, 0);
        cmp(rd, 32'h10);
        apb(1'b0, 8'h0C, 0);
        cmp(rd, 32'h0);
        cmp(32'(er), 32'h1);
        apb(1'b1, 8'h00, 32'h1);
        ctrl_u.send_hs(4, 1'b1);
        cmp(bits.size(), 0);
        apb(1'b1, 8'h04, 32'h05DD);
        apb(1'b0, 8'h04, 0);
        cmp(rd, 32'h05DD);
        ctrl_u.send_hs(12, 1'b1);
        wt(0, 1'b1);
        cmp(32'(bits.size() > 48), 32'h1);
        repeat (4) begin
            bits.delete();
            ctrl_u.taken.delete();
            m = 1 + $urandom % 5;
            ctrl_u.send_hs(m, 1'b0);
            cmp(ctrl_u.taken.size(), m);
            wt(0, 1'b1);
            chk_stream();
        end
        fork
            ctrl_u.send_hs(8, 1'b0);
        join_none
        wt(2, 1'b1);
        force_stop <= 1'b1;
        repeat (6) @(posedge pclk);
        cmp({stop_state, hs_tx_ready}, 2'b10);
        force_stop <= 1'b0;
        wait fork;
        lane_enable <= 1'b0;
        repeat (6) @(posedge pclk);
        cmp({stop_state, ulps_active_n, line.lp_p, line.lp_n}, 4'h4);
        lane_enable <= 1'b1;
        wt(0, 1'b1);
        ctrl_u.esc_exit();
        repeat (40) @(posedge pclk);
        cmp(stop_state, 1'b1);
        ctrl_u.esc_off();
        ctrl_u.esc_on(1'b0, 1'b1, 4'h0);
        wt(1, 1'b0);
        repeat (60) @(posedge pclk);
        cmp(ulps_active_n, 1'b0);
        ctrl_u.esc_exit();
        wt(1, 1'b1);
        repeat (60) @(posedge pclk);
        cmp({stop_state, line.lp_p, line.lp_n}, 3'h2);
        ctrl_u.esc_off();
        wt(0, 1'b1);
        for (int k = 0; k < 5; k++) begin
            ctrl_u.esc_on(k == 0, 1'b0, (k == 0) ? 4'h0 : 4'(1 << (k - 1)));
            repeat (100) @(posedge pclk);
            cmp({stop_state, ulps_active_n}, 2'b01);
            ctrl_u.esc_off();
            wt(0, 1'b1);
        end
        report_and_stop();
    end
endmodule
